// File: logic/droop_monitor_pkg.sv
// Constants, field layout and types for the supply droop monitor.
// Assumes a single 200 MHz core clock and an AXI4-Lite register bus.
`default_nettype none

package droop_monitor_pkg;

  // ---------------------------------------------------------------
  // Bus
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          STRB_W      = DATA_W / 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] FLAG_OFFSET = 8'h04;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          UPPER_LANE  = 1;

  // ---------------------------------------------------------------
  // Control register fields (16 bits, upper bits read zero)
  // ---------------------------------------------------------------
  localparam int          REF_STABLE_BIT = 13;
  localparam int          ENABLE_BIT     = 12;
  localparam int          LEVEL_MSB      = 11;
  localparam int          LEVEL_LSB      = 8;
  localparam int          LEVEL_W        = LEVEL_MSB - LEVEL_LSB + 1;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h5;
  localparam logic [LEVEL_W-1:0] LEVEL_EXT   = 4'hF;
  localparam int          TAP_COUNT      = 15;
  localparam logic        ENABLE_RESET   = 1'h0;

  // ---------------------------------------------------------------
  // Flag register fields
  // ---------------------------------------------------------------
  localparam int          FLAG_BIT       = 10;

  // ---------------------------------------------------------------
  // Synchroniser layout
  // ---------------------------------------------------------------
  localparam int          SYNC_W         = TAP_COUNT + 2;
  localparam int          SYNC_EXT_BIT   = TAP_COUNT;
  localparam int          SYNC_REF_BIT   = TAP_COUNT + 1;

  typedef enum logic [1:0] {SEL_CTRL, SEL_FLAG, SEL_NONE} reg_sel_t;

  // Word decode shared by read and write paths
  function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2])
      sel = SEL_CTRL;
    else if (addr[ADDR_W-1:2] == FLAG_OFFSET[ADDR_W-1:2])
      sel = SEL_FLAG;
    return sel;
  endfunction

  // Comparator result of the selected source
  function automatic logic pick_source(input logic [LEVEL_W-1:0]   level,
                                       input logic [TAP_COUNT-1:0] taps,
                                       input logic                 ext);
    logic res;
    res = ext;
    if (level != LEVEL_EXT)
      res = taps[level];
    return res;
  endfunction

endpackage : droop_monitor_pkg

`default_nettype wire

// File: logic/supply_droop_monitor.sv
// Supply droop monitor control: AXI4-Lite registers, source select, flag.
// Assumes analog comparators outside, one per tap plus external pin.
`default_nettype none

module supply_droop_monitor (
  input  wire logic                                    core_clk,
  input  wire logic                                    arst_n,
  input  wire logic [droop_monitor_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                                    awvalid,
  output var  logic                                    awready,
  input  wire logic [droop_monitor_pkg::DATA_W-1:0]    wdata,
  input  wire logic [droop_monitor_pkg::STRB_W-1:0]    wstrb,
  input  wire logic                                    wvalid,
  output var  logic                                    wready,
  output var  logic [1:0]                              bresp,
  output var  logic                                    bvalid,
  input  wire logic                                    bready,
  input  wire logic [droop_monitor_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                                    arvalid,
  output var  logic                                    arready,
  output var  logic [droop_monitor_pkg::DATA_W-1:0]    rdata,
  output var  logic [1:0]                              rresp,
  output var  logic                                    rvalid,
  input  wire logic                                    rready,
  input  wire logic [droop_monitor_pkg::TAP_COUNT-1:0] tap_below_ref_async,
  input  wire logic                                    external_sense_below_async,
  input  wire logic                                    reference_stable_async,
  output var  logic                                    monitor_power_en,
  output var  logic [droop_monitor_pkg::LEVEL_W-1:0]   tap_select,
  output var  logic                                    droop_irq_flag
);

  import droop_monitor_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0]    sync_q;
  logic [TAP_COUNT-1:0] tap_below;
  logic                 ext_below;
  logic                 reference_stable;
  logic                 sel_below;
  logic                 aw_got_ff;
  logic                 w_got_ff;
  logic [ADDR_W-1:0]    aw_addr_ff;
  logic [DATA_W-1:0]    w_data_ff;
  logic [STRB_W-1:0]    w_strb_ff;
  logic                 aw_fire;
  logic                 w_fire;
  logic                 ar_fire;
  logic                 have_aw;
  logic                 have_w;
  logic                 do_write;
  logic [ADDR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]    wr_data;
  logic [STRB_W-1:0]    wr_strb;
  reg_sel_t             wr_sel;
  logic                 ctrl_wr;
  logic                 flag_clear;
  logic                 flag_set;
  logic                 nxt_aw_got;
  logic                 nxt_w_got;
  logic                 nxt_bvalid;
  logic                 nxt_rvalid;
  logic [DATA_W-1:0]    nxt_rdata;
  logic                 first_cycle_ff;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  sync_two_stage #(
    .W (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({reference_stable_async, external_sense_below_async, tap_below_ref_async}),
    .sync_out (sync_q)
  );

  assign tap_below        = sync_q[TAP_COUNT-1:0];
  assign ext_below        = sync_q[SYNC_EXT_BIT];
  assign reference_stable = sync_q[SYNC_REF_BIT];

  // ---------------------------------------------------------------
  // Source select
  // ---------------------------------------------------------------
  assign sel_below = pick_source(tap_select, tap_below, ext_below);

  // ---------------------------------------------------------------
  // Write channel handshake
  // ---------------------------------------------------------------
  assign aw_fire  = awvalid && awready;
  assign w_fire   = wvalid && wready;
  assign have_aw  = aw_got_ff || aw_fire;
  assign have_w   = w_got_ff || w_fire;
  assign do_write = have_aw && have_w;
  assign wr_addr  = aw_got_ff ? aw_addr_ff : awaddr;
  assign wr_data  = w_got_ff ? w_data_ff : wdata;
  assign wr_strb  = w_got_ff ? w_strb_ff : wstrb;
  assign wr_sel   = decode_reg(wr_addr);

  assign nxt_aw_got = have_aw && !do_write;
  assign nxt_w_got  = have_w && !do_write;
  assign nxt_bvalid = do_write || (bvalid && !bready);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff  <= nxt_w_got;
      awready   <= !nxt_aw_got && !nxt_bvalid;
      wready    <= !nxt_w_got && !nxt_bvalid;
      bvalid    <= nxt_bvalid;
      if (do_write)
        bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
    end
    else
    begin
      if (aw_fire)
        aw_addr_ff <= awaddr;
      if (w_fire)
      begin
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  assign ctrl_wr = do_write && (wr_sel == SEL_CTRL) && wr_strb[UPPER_LANE];

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      monitor_power_en <= ENABLE_RESET;
      tap_select       <= LEVEL_RESET;
    end
    else if (ctrl_wr)
    begin
      monitor_power_en <= wr_data[ENABLE_BIT];
      tap_select       <= wr_data[LEVEL_MSB:LEVEL_LSB];
    end
  end

  // ---------------------------------------------------------------
  // Droop flag
  // ---------------------------------------------------------------
  // Writing zero to the flag bit clears it; a new detection wins
  assign flag_clear = do_write && (wr_sel == SEL_FLAG) && wr_strb[UPPER_LANE]
                      && !wr_data[FLAG_BIT];
  // Gated only by monitor_power_en, no other power-mode gating
  assign flag_set   = monitor_power_en && sel_below;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      droop_irq_flag <= 1'b0;
    else
      droop_irq_flag <= flag_set || (droop_irq_flag && !flag_clear);
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign ar_fire    = arvalid && arready;
  assign nxt_rvalid = ar_fire || (rvalid && !rready);

  always_comb
  begin
    nxt_rdata = '0;
    case (decode_reg(araddr))
      SEL_CTRL:
      begin
        nxt_rdata[REF_STABLE_BIT]      = reference_stable;
        nxt_rdata[ENABLE_BIT]          = monitor_power_en;
        nxt_rdata[LEVEL_MSB:LEVEL_LSB] = tap_select;
      end
      SEL_FLAG:
        nxt_rdata[FLAG_BIT] = droop_irq_flag;
      default:
        nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else
    begin
      arready <= !nxt_rvalid;
      rvalid  <= nxt_rvalid;
      if (ar_fire)
      begin
        rdata <= nxt_rdata;
        rresp <= (decode_reg(araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      first_cycle_ff <= 1'b1;
    else
      first_cycle_ff <= 1'b0;
  end

  property p_flag_set;
    @(posedge core_clk) disable iff (!arst_n)
    (monitor_power_en && sel_below) |=> droop_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on droop");

  property p_enable_write;
    @(posedge core_clk) disable iff (!arst_n)
    ctrl_wr |=> (monitor_power_en == $past(wr_data[ENABLE_BIT]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not written");

  property p_level_write;
    @(posedge core_clk) disable iff (!arst_n)
    ctrl_wr |=> (tap_select == $past(wr_data[LEVEL_MSB:LEVEL_LSB]));
  endproperty
  a_level_write: assert property (p_level_write) else $error("level not written");

  property p_ext_source;
    @(posedge core_clk) disable iff (!arst_n)
    (monitor_power_en && tap_select == LEVEL_EXT && ext_below) |=> droop_irq_flag;
  endproperty
  a_ext_source: assert property (p_ext_source) else $error("external source ignored");

  property p_tap_source;
    @(posedge core_clk) disable iff (!arst_n)
    (monitor_power_en && tap_select != LEVEL_EXT && tap_below[tap_select]) |=> droop_irq_flag;
  endproperty
  a_tap_source: assert property (p_tap_source) else $error("internal tap ignored");

  property p_reset_level;
    @(posedge core_clk) disable iff (!arst_n)
    first_cycle_ff |-> (tap_select == LEVEL_RESET && !monitor_power_en && !droop_irq_flag);
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("bad reset values");

  property p_stable_read;
    @(posedge core_clk) disable iff (!arst_n)
    (ar_fire && decode_reg(araddr) == SEL_CTRL) |=> (rvalid && rdata[REF_STABLE_BIT] == $past(reference_stable));
  endproperty
  a_stable_read: assert property (p_stable_read) else $error("stable bit misread");

  property p_flag_hold;
    @(posedge core_clk) disable iff (!arst_n)
    (droop_irq_flag && !flag_clear) |=> droop_irq_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

  property p_flag_needs_enable;
    @(posedge core_clk) disable iff (!arst_n)
    $rose(droop_irq_flag) |-> ($past(monitor_power_en) && $past(sel_below));
  endproperty
  a_flag_needs_enable: assert property (p_flag_needs_enable) else $error("flag set while disabled");

  // Response one cycle after both halves are in, channels closed meanwhile
  property p_write_answer;
    @(posedge core_clk) disable iff (!arst_n)
    do_write |=> (bvalid && !awready && !wready);
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer wrong");

  property p_resp_stands;
    @(posedge core_clk) disable iff (!arst_n)
    (bvalid && !bready) |=> (bvalid && $stable(bresp));
  endproperty
  a_resp_stands: assert property (p_resp_stands) else $error("write response dropped");

  property p_read_answer;
    @(posedge core_clk) disable iff (!arst_n)
    ar_fire |=> (rvalid && !arready);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");

endmodule // supply_droop_monitor

`default_nettype wire

// File: logic/sync_two_stage.sv
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level from outside the core clock domain.
`default_nettype none

module sync_two_stage #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_ff  <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // sync_two_stage

`default_nettype wire

// File: test/test_supply_droop_monitor.sv
// Self-checking bench for the supply droop monitor register and flag logic.
// Assumes the design package is compiled first; bench drives all ports itself.
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("ERROR %s expected %0h got %0h", nm, exp, got); \
    end \
  end

module test_supply_droop_monitor import droop_monitor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 core_clk;
  logic                 arst_n;
  logic [ADDR_W-1:0]    awaddr;
  logic                 awvalid;
  logic                 awready;
  logic [DATA_W-1:0]    wdata;
  logic [STRB_W-1:0]    wstrb;
  logic                 wvalid;
  logic                 wready;
  logic [1:0]           bresp;
  logic                 bvalid;
  logic                 bready;
  logic [ADDR_W-1:0]    araddr;
  logic                 arvalid;
  logic                 arready;
  logic [DATA_W-1:0]    rdata;
  logic [1:0]           rresp;
  logic                 rvalid;
  logic                 rready;
  logic [TAP_COUNT-1:0] taps;
  logic                 ext_below;
  logic                 ref_ok;
  logic                 monitor_power_en;
  logic [LEVEL_W-1:0]   tap_select;
  logic                 droop_irq_flag;
  int                   failures;
  int                   n_compared;

  supply_droop_monitor u_dut (
    .core_clk                   (core_clk),
    .arst_n                     (arst_n),
    .awaddr                     (awaddr),
    .awvalid                    (awvalid),
    .awready                    (awready),
    .wdata                      (wdata),
    .wstrb                      (wstrb),
    .wvalid                     (wvalid),
    .wready                     (wready),
    .bresp                      (bresp),
    .bvalid                     (bvalid),
    .bready                     (bready),
    .araddr                     (araddr),
    .arvalid                    (arvalid),
    .arready                    (arready),
    .rdata                      (rdata),
    .rresp                      (rresp),
    .rvalid                     (rvalid),
    .rready                     (rready),
    .tap_below_ref_async        (taps),
    .external_sense_below_async (ext_below),
    .reference_stable_async     (ref_ok),
    .monitor_power_en           (monitor_power_en),
    .tap_select                 (tap_select),
    .droop_irq_flag             (droop_irq_flag)
  );

  // ---------------------------------------------------------------
  // Clock, watchdog, verdict
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    $display("ERROR watchdog expired");
    summarize();
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
                    input logic [STRB_W-1:0] strb, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    awaddr  <= addr;
    wdata   <= data;
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    `CHK("write cycles", 2, n)
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp,
                    input logic [1:0] er, input string nm);
    int n;
    @(posedge core_clk);
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    `CHK("read cycles", 2, n)
    `CHK(nm, exp, rdata)
    `CHK("rresp", er, rresp)
  endtask

  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    failures = 0;
    n_compared = 0;
    arst_n = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, taps, ext_below, ref_ok} = '0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    `CHK("tap_select", LEVEL_RESET, tap_select)
    `CHK("power", 1'b0, monitor_power_en)
    rd(CTRL_OFFSET, 32'h0000_0500, RESP_OKAY, "ctrl reset");
    rd(FLAG_OFFSET, 32'h0000_0000, RESP_OKAY, "flag reset");
    $display("test reset done");

    // Disabled detector ignores every source
    taps      <= '1;
    ext_below <= 1'b1;
    ref_ok    <= 1'b1;
    settle();
    `CHK("flag off", 1'b0, droop_irq_flag)
    wr(CTRL_OFFSET, 32'h0000_1500, 4'hF, RESP_OKAY);
    rd(CTRL_OFFSET, 32'h0000_3500, RESP_OKAY, "stable at enable");
    `CHK("power", 1'b1, monitor_power_en)
    $display("test enable done");

    // Every level code: only the selected source sets the flag
    for (int c = 0; c < 16; c++)
    begin
      taps      <= (c == 15) ? '1 : ~(15'h1 << c);
      ext_below <= (c != 15);
      wr(CTRL_OFFSET, 32'h0000_1000 | (c << 8), 4'hF, RESP_OKAY);
      `CHK("tap_select", c[3:0], tap_select)
      settle();
      wr(FLAG_OFFSET, 32'h0, 4'hF, RESP_OKAY);
      settle();
      `CHK("flag other source", 1'b0, droop_irq_flag)
      if (c == 15)
        ext_below <= 1'b1;
      else
        taps[c] <= 1'b1;
      settle();
      `CHK("flag selected", 1'b1, droop_irq_flag)
      taps      <= '0;
      ext_below <= 1'b0;
      settle();
      wr(FLAG_OFFSET, 32'h0, 4'hF, RESP_OKAY);
    end
    $display("test level sweep done");

    // Sticky flag and clear semantics
    wr(CTRL_OFFSET, 32'h0000_1500, 4'hF, RESP_OKAY);
    taps[5] <= 1'b1;
    settle();
    taps[5] <= 1'b0;
    settle();
    `CHK("flag sticky", 1'b1, droop_irq_flag)
    wr(FLAG_OFFSET, 32'h0000_0400, 4'hF, RESP_OKAY);
    wr(FLAG_OFFSET, 32'h0, 4'h1, RESP_OKAY);
    rd(FLAG_OFFSET, 32'h0000_0400, RESP_OKAY, "flag kept");
    wr(FLAG_OFFSET, 32'h0, 4'hF, RESP_OKAY);
    rd(FLAG_OFFSET, 32'h0, RESP_OKAY, "flag cleared");
    $display("test sticky done");

    // Disable keeps flag, blocks new sets; status bit read-only
    taps[5] <= 1'b1;
    settle();
    wr(CTRL_OFFSET, 32'hFFFF_C500, 4'hF, RESP_OKAY);
    `CHK("flag after disable", 1'b1, droop_irq_flag)
    `CHK("power", 1'b0, monitor_power_en)
    wr(FLAG_OFFSET, 32'h0, 4'hF, RESP_OKAY);
    settle();
    `CHK("flag disabled", 1'b0, droop_irq_flag)
    rd(CTRL_OFFSET, 32'h0000_2500, RESP_OKAY, "ctrl ro bits");
    wr(CTRL_OFFSET, 32'h0000_1200, 4'h1, RESP_OKAY);
    `CHK("tap_select", 4'h5, tap_select)
    ref_ok <= 1'b0;
    settle();
    rd(CTRL_OFFSET, 32'h0000_0500, RESP_OKAY, "stable low");
    rd(8'h08, 32'h0, RESP_SLVERR, "unmapped");
    wr(8'h08, 32'h0000_1F00, 4'hF, RESP_SLVERR);
    rd(CTRL_OFFSET, 32'h0000_0500, RESP_OKAY, "ctrl intact");
    $display("test disable and access done");
    summarize();
  end

endmodule // test_supply_droop_monitor

`undef CHK

`default_nettype wire
